// [core/acsc_pkg.sv]
package acsc_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] ACSC_IDX_AUX_ONE  = 30'h0000_00f8;
    localparam logic [29:0] ACSC_IDX_AUX_TWO  = 30'h0000_00f7;
    localparam logic [29:0] ACSC_IDX_BG_TRIM  = 30'h0000_1ffb;
    localparam logic [29:0] ACSC_IDX_OSC_TRIM = 30'h0000_1ffd;
    localparam logic [29:0] ACSC_IDX_CODE_PROTECT_CFG = 30'h0000_1fff;
    localparam logic [29:0] ACSC_IDX_INT_STAT = 30'h0000_0100;
    localparam logic [29:0] ACSC_IDX_INT_CLR  = 30'h0000_0101;
    localparam logic [29:0] ACSC_IDX_INT_EN   = 30'h0000_0102;

    // slots of the configuration word store
    localparam logic [1:0] ACSC_CFG_BG   = 2'h0;
    localparam logic [1:0] ACSC_CFG_OSC  = 2'h1;
    localparam logic [1:0] ACSC_CFG_CODE_PROTECT = 2'h2;

    // aux_control_one fields
    localparam int ACSC_A1_WDT_CLR   = 7;
    localparam int ACSC_A1_TM3_CLR   = 6;
    localparam int ACSC_A1_REF_FORCE = 5;
    localparam int ACSC_A1_CONV      = 4;
    localparam int ACSC_A1_PWM0      = 3;
    localparam int ACSC_A1_PWMG      = 2;
    localparam int ACSC_A1_POINTER_SELECT     = 0;
    localparam logic [7:0] ACSC_A1_RST  = 8'h0c;
    localparam logic [7:0] ACSC_A1_MASK = 8'hfd;

    // aux_control_two fields
    localparam int ACSC_A2_WDT_HI  = 7;
    localparam int ACSC_A2_WDT_LO  = 6;
    localparam int ACSC_A2_LOW_POWER_SAVING  = 5;
    localparam int ACSC_A2_REFOUT  = 4;
    localparam int ACSC_A2_LONG_DIVIDE_SEL   = 3;
    localparam int ACSC_A2_GUARD_HI = 2;
    localparam int ACSC_A2_GUARD_LO = 1;
    localparam int ACSC_A2_WIDE    = 0;
    localparam logic [7:0] ACSC_A2_RST = 8'h06;

    // protect_reset_config_word fields, bits 1..0 carry no function
    localparam int ACSC_PC_CODE_PROTECT   = 7;
    localparam int ACSC_PC_PINRST = 6;
    localparam int ACSC_PC_UVR_HI = 5;
    localparam int ACSC_PC_UVR_LO = 2;
    localparam logic [7:0] ACSC_CFG_RST = 8'h00;

    localparam logic [3:0] ACSC_REF_PIN_CHAN = 4'hc;
    localparam logic [1:0] ACSC_WDT_ALWAYS   = 2'h3;
    localparam logic [1:0] ACSC_WDT_RUNONLY  = 2'h2;

    // interrupt status bits
    localparam int ACSC_INT_GUARD = 0;
    localparam int ACSC_INT_CONV  = 1;
    localparam int ACSC_INT_W     = 2;

    // program guard times
    localparam int ACSC_CLK_PERIOD_NS = 100;
    localparam int ACSC_GUARD1_US = 1600;
    localparam int ACSC_GUARD2_US = 3200;
    localparam int ACSC_GUARD3_US = 12800;
    localparam int ACSC_GUARD1_CYC = ACSC_GUARD1_US * 1000
                                     / ACSC_CLK_PERIOD_NS;
    localparam int ACSC_GUARD2_CYC = ACSC_GUARD2_US * 1000
                                     / ACSC_CLK_PERIOD_NS;
    localparam int ACSC_GUARD3_CYC = ACSC_GUARD3_US * 1000
                                     / ACSC_CLK_PERIOD_NS;
    localparam int ACSC_GUARD_W = 17;

    typedef enum logic [2:0] {
        ACSC_PM_FAST = 3'b000,
        ACSC_PM_SLOW = 3'b001,
        ACSC_PM_IDLE = 3'b010,
        ACSC_PM_HALT = 3'b011,
        ACSC_PM_STOP = 3'b100
    } acsc_pmode_e;

    typedef enum logic [1:0] {
        ACSC_BUS_IDLE = 2'b00,
        ACSC_BUS_DATA = 2'b01
    } acsc_bus_e;

endpackage : acsc_pkg

// [core/acsc_cfg_mem.sv]
`timescale 1ns/1ps

// configuration word store; read data leave through a register
module acsc_cfg_mem (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // load port
    input  wire logic       we,
    input  wire logic [1:0] waddr,
    input  wire logic [7:0] wdata,
    // read port
    input  wire logic [1:0] raddr,
    output logic      [7:0] rdata
);
    import acsc_pkg::*;

    logic [7:0] mem_r [4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= ACSC_CFG_RST;
            end
            rdata <= ACSC_CFG_RST;
        end else begin
            if (we) begin
                mem_r[waddr] <= wdata;
            end
            rdata <= mem_r[raddr];
        end
    end

endmodule : acsc_cfg_mem

// [core/acsc_top.sv]
`timescale 1ns/1ps

module acsc_top #(
    parameter int GUARD1_CYC = acsc_pkg::ACSC_GUARD1_CYC,
    parameter int GUARD2_CYC = acsc_pkg::ACSC_GUARD2_CYC,
    parameter int GUARD3_CYC = acsc_pkg::ACSC_GUARD3_CYC
) (
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // system state
    input  wire acsc_pkg::acsc_pmode_e power_mode,
    input  wire logic [3:0]  adc_channel_sel,
    input  wire logic        adc_conv_done,
    input  wire logic        ref_auto_req,
    input  wire logic        prog_write_busy,
    // configuration load from flash
    input  wire logic        cfg_load,
    input  wire logic [1:0]  cfg_load_sel,
    input  wire logic [7:0]  cfg_load_data,
    // control outputs
    output logic             watchdog_enable,
    output logic             watchdog_clear,
    output logic             timer_three_clear,
    output logic             low_power_saving,
    output logic             reference_pin_output,
    output logic             reference_enable,
    output logic             conversion_start,
    output logic             pwm_zero_hold,
    output logic             pwm_group_hold,
    output logic             pointer_select,
    output logic             wide_muldiv_sel,
    output logic             long_divide_sel,
    output logic             program_guard_timeout,
    // configuration outputs
    output logic             code_protect,
    output logic             pin_reset_enable,
    output logic      [3:0]  undervoltage_reset_sel,
    output logic      [6:0]  osc_trim,
    output logic      [4:0]  reference_trim,
    // interrupt
    output logic             irq
);
    import acsc_pkg::*;

    function automatic logic hit(input logic [29:0] a,
                                 input logic [29:0] idx);
        hit = (a == idx);
    endfunction : hit

    function automatic logic sleeping(input acsc_pmode_e m);
        sleeping = (m == ACSC_PM_IDLE) || (m == ACSC_PM_HALT)
                   || (m == ACSC_PM_STOP);
    endfunction : sleeping

    acsc_bus_e   bus_r;
    acsc_bus_e   bus_nxt;
    logic [29:0] addr_r;
    logic        wr_r;
    logic [7:0]  aux_control_one_r;
    logic [7:0]  aux_control_one_nxt;
    logic [7:0]  aux_control_two_r;
    logic [7:0]  aux_control_two_nxt;
    logic [ACSC_INT_W-1:0] stat_r;
    logic [ACSC_INT_W-1:0] stat_nxt;
    logic [ACSC_INT_W-1:0] en_r;
    logic [ACSC_GUARD_W-1:0] guard_cnt_r;
    logic        guard_fired_r;
    logic [7:0]  cfg_rdata;

    // bus decode
    wire         accept   = hsel && htrans[1] && hready
                            && (bus_r == ACSC_BUS_IDLE);
    wire [29:0]  acc_idx  = haddr[31:2];
    wire         do_wr    = (bus_r == ACSC_BUS_DATA) && wr_r;
    wire         do_rd    = (bus_r == ACSC_BUS_DATA) && !wr_r;
    wire         wr_aux_control_one  = do_wr && hit(addr_r, ACSC_IDX_AUX_ONE);
    wire         wr_aux_control_two  = do_wr && hit(addr_r, ACSC_IDX_AUX_TWO);
    wire         wr_clr   = do_wr && hit(addr_r, ACSC_IDX_INT_CLR);
    wire         wr_en    = do_wr && hit(addr_r, ACSC_IDX_INT_EN);
    wire         rd_cfg   = hit(addr_r, ACSC_IDX_BG_TRIM)
                            || hit(addr_r, ACSC_IDX_OSC_TRIM)
                            || hit(addr_r, ACSC_IDX_CODE_PROTECT_CFG);
    wire [1:0]   cfg_raddr = hit(acc_idx, ACSC_IDX_OSC_TRIM) ? ACSC_CFG_OSC
                           : hit(acc_idx, ACSC_IDX_CODE_PROTECT_CFG)
                             ? ACSC_CFG_CODE_PROTECT : ACSC_CFG_BG;
    wire [7:0]   wbyte    = hwdata[7:0];

    // read data select; unmapped reads return zero
    wire [7:0]   rd_byte  =
          hit(addr_r, ACSC_IDX_AUX_ONE)  ? aux_control_one_r
        : hit(addr_r, ACSC_IDX_AUX_TWO)  ? aux_control_two_r
        : hit(addr_r, ACSC_IDX_INT_STAT)
          ? {{(8-ACSC_INT_W){1'b0}}, stat_r}
        : hit(addr_r, ACSC_IDX_INT_EN)
          ? {{(8-ACSC_INT_W){1'b0}}, en_r}
        : rd_cfg ? cfg_rdata : 8'h00;

    // watchdog mode decode
    wire [1:0]   wdt_mode = aux_control_two_r[ACSC_A2_WDT_HI:ACSC_A2_WDT_LO];
    wire         wdt_on   = (wdt_mode == ACSC_WDT_ALWAYS)
                            || ((wdt_mode == ACSC_WDT_RUNONLY)
                                && !sleeping(power_mode));

    // program guard limit select
    wire [1:0]   guard_sel = aux_control_two_r[ACSC_A2_GUARD_HI:ACSC_A2_GUARD_LO];
    wire [ACSC_GUARD_W-1:0] guard_lim =
          (guard_sel == 2'h1) ? ACSC_GUARD_W'(GUARD1_CYC - 1)
        : (guard_sel == 2'h2) ? ACSC_GUARD_W'(GUARD2_CYC - 1)
        : ACSC_GUARD_W'(GUARD3_CYC - 1);
    wire         guard_run = prog_write_busy && (guard_sel != 2'h0)
                             && !guard_fired_r;
    wire         guard_hit = guard_run && (guard_cnt_r == guard_lim);

    // aux_control_one next value
    always_comb begin
        aux_control_one_nxt = aux_control_one_r;
        // strobe bits live one cycle only
        aux_control_one_nxt[ACSC_A1_WDT_CLR] = 1'b0;
        aux_control_one_nxt[ACSC_A1_TM3_CLR] = 1'b0;
        if (adc_conv_done) begin
            aux_control_one_nxt[ACSC_A1_CONV] = 1'b0;
        end
        if (wr_aux_control_one) begin
            // a fresh start write wins over an ending conversion
            aux_control_one_nxt = wbyte & ACSC_A1_MASK;
        end
    end

    assign aux_control_two_nxt = wr_aux_control_two ? wbyte : aux_control_two_r;

    // sticky events; a new event wins over a clear in the same cycle
    always_comb begin
        stat_nxt = stat_r;
        if (wr_clr) begin
            stat_nxt = stat_r & ~wbyte[ACSC_INT_W-1:0];
        end
        if (guard_hit) begin
            stat_nxt[ACSC_INT_GUARD] = 1'b1;
        end
        if (adc_conv_done && aux_control_one_r[ACSC_A1_CONV]) begin
            stat_nxt[ACSC_INT_CONV] = 1'b1;
        end
    end

    always_comb begin
        case (bus_r)
            ACSC_BUS_IDLE: bus_nxt = accept ? ACSC_BUS_DATA
                                            : ACSC_BUS_IDLE;
            ACSC_BUS_DATA: bus_nxt = ACSC_BUS_IDLE;
            default:       bus_nxt = ACSC_BUS_IDLE;
        endcase
    end

    // bus slave: one wait state on every transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r     <= ACSC_BUS_IDLE;
            addr_r    <= 30'h0;
            wr_r      <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0;
            hresp     <= 1'b0;
        end else begin
            bus_r     <= bus_nxt;
            hreadyout <= !accept;
            hresp     <= 1'b0;
            if (accept) begin
                addr_r <= acc_idx;
                wr_r   <= hwrite;
            end
            if (do_rd) begin
                hrdata <= {24'h0, rd_byte};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_control_one_r <= ACSC_A1_RST;
            aux_control_two_r <= ACSC_A2_RST;
            stat_r <= '0;
            en_r   <= '0;
            irq    <= 1'b0;
        end else begin
            aux_control_one_r <= aux_control_one_nxt;
            aux_control_two_r <= aux_control_two_nxt;
            stat_r <= stat_nxt;
            if (wr_en) begin
                en_r <= wbyte[ACSC_INT_W-1:0];
            end
            irq    <= |(stat_nxt & en_r);
        end
    end

    // program guard counter, restarts with every new write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_cnt_r           <= '0;
            guard_fired_r         <= 1'b0;
            program_guard_timeout <= 1'b0;
        end else begin
            program_guard_timeout <= guard_hit;
            if (!prog_write_busy || guard_sel == 2'h0) begin
                guard_cnt_r   <= '0;
                guard_fired_r <= 1'b0;
            end else if (guard_hit) begin
                guard_fired_r <= 1'b1;
            end else if (guard_run) begin
                guard_cnt_r <= guard_cnt_r + 1'b1;
            end
        end
    end

    // control outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_enable      <= 1'b0;
            watchdog_clear       <= 1'b0;
            timer_three_clear    <= 1'b0;
            low_power_saving     <= 1'b0;
            reference_pin_output <= 1'b0;
            reference_enable     <= 1'b0;
            conversion_start     <= 1'b0;
            pwm_zero_hold        <= 1'b1;
            pwm_group_hold       <= 1'b1;
            pointer_select       <= 1'b0;
            wide_muldiv_sel      <= 1'b0;
            long_divide_sel      <= 1'b0;
        end else begin
            watchdog_enable   <= wdt_on;
            watchdog_clear    <= aux_control_one_nxt[ACSC_A1_WDT_CLR];
            timer_three_clear <= aux_control_one_nxt[ACSC_A1_TM3_CLR];
            low_power_saving  <= aux_control_two_nxt[ACSC_A2_LOW_POWER_SAVING]
                                 && sleeping(power_mode);
            reference_pin_output <= aux_control_two_nxt[ACSC_A2_REFOUT]
                && (adc_channel_sel == ACSC_REF_PIN_CHAN);
            // forcing never holds the reference on while asleep
            reference_enable <= aux_control_one_nxt[ACSC_A1_REF_FORCE]
                                ? !sleeping(power_mode)
                                : ref_auto_req;
            conversion_start <= aux_control_one_nxt[ACSC_A1_CONV];
            pwm_zero_hold    <= aux_control_one_nxt[ACSC_A1_PWM0];
            pwm_group_hold   <= aux_control_one_nxt[ACSC_A1_PWMG];
            pointer_select   <= aux_control_one_nxt[ACSC_A1_POINTER_SELECT];
            wide_muldiv_sel  <= aux_control_two_nxt[ACSC_A2_WIDE];
            long_divide_sel  <= aux_control_two_nxt[ACSC_A2_WIDE]
                                && aux_control_two_nxt[ACSC_A2_LONG_DIVIDE_SEL];
        end
    end

    // configuration fields captured as the flash loader writes them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_protect           <= 1'b0;
            pin_reset_enable       <= 1'b0;
            undervoltage_reset_sel <= 4'h0;
            osc_trim               <= 7'h00;
            reference_trim         <= 5'h00;
        end else if (cfg_load) begin
            case (cfg_load_sel)
                ACSC_CFG_CODE_PROTECT: begin
                    code_protect <= cfg_load_data[ACSC_PC_CODE_PROTECT];
                    pin_reset_enable <=
                        cfg_load_data[ACSC_PC_PINRST];
                    undervoltage_reset_sel <= cfg_load_data[
                        ACSC_PC_UVR_HI:ACSC_PC_UVR_LO];
                    // bits 1..0 are kept in the store only
                end
                ACSC_CFG_OSC: begin
                    osc_trim <= cfg_load_data[6:0];
                end
                ACSC_CFG_BG: begin
                    reference_trim <= cfg_load_data[4:0];
                end
                default: begin
                    osc_trim <= osc_trim;
                end
            endcase
        end
    end

    acsc_cfg_mem u_cfg_mem (
        .clk   (hclk),
        .rst_n (hresetn),
        .we    (cfg_load),
        .waddr (cfg_load_sel),
        .wdata (cfg_load_data),
        .raddr (cfg_raddr),
        .rdata (cfg_rdata)
    );

endmodule : acsc_top

// [tb/acsc_properties.sv]
`timescale 1ns/1ps

module acsc_properties #(
    parameter int GUARD1_CYC = 8
) (
    // clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // bus and system state
    input wire logic                  hreadyout,
    input wire acsc_pkg::acsc_pmode_e power_mode,
    input wire logic [3:0]            adc_channel_sel,
    input wire logic                  adc_conv_done,
    input wire logic                  ref_auto_req,
    input wire logic                  prog_write_busy,
    // control outputs
    input wire logic                  watchdog_clear,
    input wire logic                  timer_three_clear,
    input wire logic                  low_power_saving,
    input wire logic                  reference_pin_output,
    input wire logic                  reference_enable,
    input wire logic                  conversion_start,
    input wire logic                  pwm_zero_hold,
    input wire logic                  pwm_group_hold,
    input wire logic                  wide_muldiv_sel,
    input wire logic                  program_guard_timeout
);
    import acsc_pkg::*;

    // the guard pulse needs at least this many busy cycles behind it
    localparam int G1M = GUARD1_CYC - 1;

    wire asleep;
    assign asleep = power_mode inside {ACSC_PM_IDLE, ACSC_PM_HALT,
                                       ACSC_PM_STOP};

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // a done with no bus write landing at the same edge
    sequence s_done_quiet;
        conversion_start && adc_conv_done && hreadyout;
    endsequence
    sequence s_start_gone;
        ##[1:2] !conversion_start;
    endsequence

    a_wdt_clr_pulse: assert property (
        watchdog_clear |=> !watchdog_clear)
        else $error("watchdog clear longer than one cycle");
    a_tm3_clr_pulse: assert property (
        timer_three_clear |=> !timer_three_clear)
        else $error("timer clear longer than one cycle");
    a_refpin_channel: assert property (
        reference_pin_output |-> $past(adc_channel_sel) == ACSC_REF_PIN_CHAN)
        else $error("reference on pin with wrong channel");
    a_lowpow_sleep: assert property (
        low_power_saving |-> $past(asleep))
        else $error("power saving outside sleep modes");
    a_ref_sleep_off: assert property (
        $past(asleep) && !$past(ref_auto_req) |-> !reference_enable)
        else $error("reference forced on while asleep");
    a_conv_done_clears: assert property (
        s_done_quiet |-> s_start_gone)
        else $error("conversion start not cleared at end");
    a_reset_holds: assert property (
        $rose(hresetn) |-> pwm_zero_hold && pwm_group_hold
                           && !wide_muldiv_sel)
        else $error("wrong control values after reset");
    a_guard_single: assert property (
        program_guard_timeout |=> !program_guard_timeout)
        else $error("guard timeout longer than one cycle");
    a_guard_min_wait: assert property (
        program_guard_timeout |-> $past(prog_write_busy, G1M))
        else $error("guard timeout without a long enough write");

endmodule : acsc_properties

bind acsc_top acsc_properties #(.GUARD1_CYC(GUARD1_CYC)) u_props (
    .hclk, .hresetn, .hreadyout, .power_mode, .adc_channel_sel,
    .adc_conv_done, .ref_auto_req, .prog_write_busy, .watchdog_clear,
    .timer_three_clear, .low_power_saving, .reference_pin_output,
    .reference_enable, .conversion_start, .pwm_zero_hold,
    .pwm_group_hold, .wide_muldiv_sel, .program_guard_timeout
);

// [tb/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    import acsc_pkg::*;

    localparam logic [31:0] A1  = {ACSC_IDX_AUX_ONE, 2'b00};
    localparam logic [31:0] A2  = {ACSC_IDX_AUX_TWO, 2'b00};
    localparam logic [31:0] PRT = {ACSC_IDX_CODE_PROTECT_CFG, 2'b00};
    localparam logic [31:0] STA = {ACSC_IDX_INT_STAT, 2'b00};
    localparam logic [31:0] CLR = {ACSC_IDX_INT_CLR, 2'b00};
    localparam logic [31:0] ENA = {ACSC_IDX_INT_EN, 2'b00};

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, cfg_load_sel;
    logic [2:0]  hsize;
    logic [3:0]  adc_channel_sel, undervoltage_reset_sel;
    logic [7:0]  cfg_load_data, a1_m, a2_m;
    logic [6:0]  osc_trim;
    logic [4:0]  reference_trim;
    logic [23:0] r;
    logic        adc_conv_done, ref_auto_req, prog_write_busy, cfg_load;
    logic        watchdog_enable, watchdog_clear, timer_three_clear;
    logic        low_power_saving, reference_pin_output, reference_enable;
    logic        conversion_start, pwm_zero_hold, pwm_group_hold;
    logic        pointer_select, wide_muldiv_sel, long_divide_sel;
    logic        program_guard_timeout, code_protect, pin_reset_enable;
    acsc_pmode_e power_mode;
    wire         hready = hreadyout;
    int          failures = 0;
    int          checks = 0;
    int          n, p;
    int          gt[4] = '{0, 8, 16, 32};
    // select, data, power mode, channel, automatic request
    logic [23:0] rows[17] = '{24'h2c00c0, 24'h2c04c0, 24'h280100,
        24'h280200, 24'h240000, 24'h220300, 24'h220000, 24'h2100c0,
        24'h2100b0, 24'h208000, 24'h209000, 24'h201000, 24'h120000,
        24'h120200, 24'h100001, 24'h101000, 24'h10c000};

    acsc_top #(.GUARD1_CYC(8), .GUARD2_CYC(16), .GUARD3_CYC(32)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .power_mode,
        .adc_channel_sel, .adc_conv_done, .ref_auto_req, .prog_write_busy,
        .cfg_load, .cfg_load_sel, .cfg_load_data, .watchdog_enable,
        .watchdog_clear, .timer_three_clear, .low_power_saving,
        .reference_pin_output, .reference_enable, .conversion_start,
        .pwm_zero_hold, .pwm_group_hold, .pointer_select,
        .wide_muldiv_sel, .long_divide_sel, .program_guard_timeout,
        .code_protect, .pin_reset_enable, .undervoltage_reset_sel,
        .osc_trim, .reference_trim, .irq
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one edge at least, then until ready is sampled high
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 20) begin
                failures++;
                complete_run();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [7:0] d);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic load(input logic [1:0] s, input logic [7:0] d);
        cfg_load <= 1'b1;
        cfg_load_sel <= s;
        cfg_load_data <= d;
        @(posedge hclk);
        cfg_load <= 1'b0;
        // let an edge pass so a following load raises the strobe anew
        @(posedge hclk);
    endtask : load

    task automatic conv_done();
        adc_conv_done <= 1'b1;
        @(posedge hclk);
        adc_conv_done <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : conv_done

    function automatic logic [8:0] model(input logic [7:0] o, t,
                                         input logic [23:0] x);
        logic slp;
        slp = x[10:8] >= 3'b010;
        return {t[7] & (t[6] | !slp), t[5] & slp,
                t[4] & (x[7:4] == ACSC_REF_PIN_CHAN), t[0], t[3] & t[0],
                o[3], o[2], o[0], (o[5] & !slp) | x[0]};
    endfunction : model

    initial begin
        {hresetn, hwrite, adc_conv_done, ref_auto_req} = 4'h0;
        {prog_write_busy, cfg_load, cfg_load_sel, cfg_load_data} = '0;
        {haddr, hwdata, htrans, adc_channel_sel} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        power_mode = ACSC_PM_FAST;
        a1_m = ACSC_A1_RST;
        a2_m = ACSC_A2_RST;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            r = rows[i];
            power_mode <= acsc_pmode_e'(r[10:8]);
            adc_channel_sel <= r[7:4];
            ref_auto_req <= r[0];
            bus(r[21] ? A2 : A1, 1'b1, r[19:12]);
            if (r[21]) a2_m = r[19:12];
            else a1_m = r[19:12];
            repeat (2) @(posedge hclk);
            chk({watchdog_enable, low_power_saving, reference_pin_output,
                 wide_muldiv_sel, long_divide_sel, pwm_zero_hold,
                 pwm_group_hold, pointer_select, reference_enable},
                model(a1_m, a2_m, r));
            bus(r[21] ? A2 : A1, 1'b0, 8'h00);
            chk(rd, {24'h0, r[19:12] & (r[21] ? 8'hff : 8'hfd)});
        end
        // reset in mid-run brings every control back
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({pwm_zero_hold, pwm_group_hold, wide_muldiv_sel},
            3'h6);
        bus(A1, 1'b0, 8'h00);
        chk(rd, 32'h0c);
        bus(A2, 1'b0, 8'h00);
        chk(rd, 32'h06);
        bus(A1, 1'b1, 8'hcc);
        // the strobes stand in the cycle that ends at the write's last edge
        n = 0;
        repeat (6) begin
            n += (watchdog_clear === 1'b1) + (timer_three_clear === 1'b1);
            @(posedge hclk);
        end
        chk(n, 2);
        bus(A1, 1'b0, 8'h00);
        chk(rd, 32'h0c);
        bus(ENA, 1'b1, 8'h03);
        bus(A1, 1'b1, 8'h1c);
        repeat (2) @(posedge hclk);
        chk(conversion_start, 1);
        conv_done();
        chk({conversion_start, irq}, 2'b01);
        bus(STA, 1'b0, 8'h00);
        chk(rd, 32'h02);
        bus(CLR, 1'b1, 8'h02);
        repeat (2) @(posedge hclk);
        chk(irq, 0);
        bus(A1, 1'b1, 8'h1c);
        bus(A1, 1'b1, 8'h0c);
        repeat (2) @(posedge hclk);
        chk(conversion_start, 0);
        // masked event still lands in status but keeps irq low
        bus(ENA, 1'b1, 8'h00);
        bus(A1, 1'b1, 8'h1c);
        repeat (2) @(posedge hclk);
        conv_done();
        chk(irq, 0);
        bus(STA, 1'b0, 8'h00);
        chk(rd, 32'h02);
        bus(CLR, 1'b1, 8'h03);
        for (int c = 0; c < 4; c++) begin
            bus(A2, 1'b1, {5'h0, c[1:0], 1'b0});
            prog_write_busy <= 1'b1;
            n = 0;
            p = 0;
            for (int k = 1; k <= 60; k++) begin
                @(posedge hclk);
                if (program_guard_timeout === 1'b1) begin
                    p++;
                    if (n == 0) n = k;
                end
            end
            prog_write_busy <= 1'b0;
            chk(p, c != 0);
            if (c != 0) chk(n >= gt[c] && n <= gt[c] + 3, 1);
        end
        bus(STA, 1'b0, 8'h00);
        chk(rd, 32'h01);
        load(2'h0, 8'hff);
        load(2'h1, 8'hff);
        load(2'h2, 8'hb6);
        repeat (3) @(posedge hclk);
        chk({reference_trim, osc_trim, code_protect, pin_reset_enable,
             undervoltage_reset_sel}, 18'h3ffed);
        bus(PRT, 1'b1, 8'h00);
        bus(PRT, 1'b0, 8'h00);
        chk(rd, 32'hb6);
        load(2'h2, 8'h43);
        repeat (3) @(posedge hclk);
        chk({code_protect, pin_reset_enable, undervoltage_reset_sel},
            6'h10);
        bus(32'h0000_0200, 1'b0, 8'h00);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
        complete_run();
    end

endmodule : tb_top
